// >>> inc/rpis_pkg.sv
// Constants shared by the run permit and interlock select block
package rpis_pkg;

  // ----------------------------------------------------------------
  // Selector codes
  // ----------------------------------------------------------------
  localparam logic [4:0] SEL_CONST0 = 5'h00;
  localparam logic [4:0] SEL_CONST1 = 5'h01;
  localparam logic [4:0] SEL_DI_FIRST = 5'h02;
  localparam logic [4:0] SEL_DI_LAST = 5'h07;
  localparam logic [4:0] SEL_NDI_FIRST = 5'h08;
  localparam logic [4:0] SEL_NDI_LAST = 5'h0d;
  localparam logic [4:0] SEL_FBA = 5'h0e;
  localparam logic [4:0] SEL_EFB = 5'h0f;
  localparam logic [4:0] SEL_OTHER = 5'h10;

  // ----------------------------------------------------------------
  // Control word bit positions
  // ----------------------------------------------------------------
  localparam int unsigned FBA_BIT = 3;
  localparam int unsigned EFB_STD_BIT = 3;
  localparam int unsigned EFB_ALT_PERMIT_BIT = 6;
  localparam int unsigned EFB_ALT_INTLK_BIT = 18;

  // ----------------------------------------------------------------
  // Command modes, trigger types, stop methods
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_NONE = 3'h0;
  localparam logic [2:0] MODE_IN1_START = 3'h1;
  localparam logic [2:0] MODE_PULSE = 3'h4;
  localparam logic TRIG_EDGE = 1'h0;
  localparam logic TRIG_LEVEL = 1'h1;
  localparam logic [1:0] STOP_NONE = 2'h0;
  localparam logic [1:0] STOP_COAST = 2'h1;
  localparam logic [1:0] STOP_RAMP = 2'h2;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CMD_MODE = 8'h00;
  localparam logic [7:0] OFS_TRIG_TYPE = 8'h04;
  localparam logic [7:0] OFS_SRC1_SEL = 8'h08;
  localparam logic [7:0] OFS_SRC2_SEL = 8'h0c;
  localparam logic [7:0] OFS_PERMIT_SEL = 8'h10;
  localparam logic [7:0] OFS_INTLK_SEL = 8'h14;
  localparam logic [7:0] OFS_STOP_MODE = 8'h18;
  localparam logic [7:0] OFS_PROFILE = 8'h1c;
  localparam logic [7:0] OFS_OTHER_IDX = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] RST_CMD_MODE = MODE_NONE;
  localparam logic RST_TRIG_TYPE = TRIG_LEVEL;
  localparam logic [4:0] RST_SRC_SEL = SEL_CONST0;
  localparam logic [4:0] RST_PERMIT_SEL = SEL_CONST1;
  localparam logic [4:0] RST_INTLK_SEL = 5'h05;
  localparam logic [1:0] RST_STOP_MODE = STOP_NONE;
  localparam logic RST_PROFILE = 1'h0;
  localparam logic [4:0] RST_OTHER_IDX = 5'h00;

endpackage

// >>> inc/rpis_src_if.sv
// Source signals shared between the top and its selectors
`timescale 1ns/1ps
`default_nettype none
interface rpis_src_if;
  logic [5:0] di_delayed;
  logic [15:0] fba_cw;
  logic [31:0] efb_cw;
  logic alt_profile;
  logic [31:0] other_status;
  modport source(output di_delayed, output fba_cw, output efb_cw,
    output alt_profile, output other_status);
  modport selector(input di_delayed, input fba_cw, input efb_cw,
    input alt_profile, input other_status);
endinterface
`default_nettype wire

// >>> rtl/rpis_selector.sv
// Code-indexed single-bit source selector
`timescale 1ns/1ps
`default_nettype none
module rpis_selector #(
  parameter bit INTERLOCK = 1'b0
) (
  input wire logic [4:0] code,
  input wire logic [4:0] other_idx,
  rpis_src_if.selector src,
  output logic level
);

  // ----------------------------------------------------------------
  // Selection
  // ----------------------------------------------------------------
  logic [4:0] di_idx;
  logic [4:0] ndi_idx;

  always_comb begin
    di_idx = code - rpis_pkg::SEL_DI_FIRST;
    ndi_idx = code - rpis_pkg::SEL_NDI_FIRST;
    level = 1'b0;
    if (code == rpis_pkg::SEL_CONST0) begin
      level = 1'b0;
    end else if (code == rpis_pkg::SEL_CONST1) begin
      level = 1'b1;
    end else if (code <= rpis_pkg::SEL_DI_LAST) begin
      level = src.di_delayed[di_idx[2:0]];
    end else if (code <= rpis_pkg::SEL_NDI_LAST) begin
      level = ~src.di_delayed[ndi_idx[2:0]];
    end else if (code == rpis_pkg::SEL_FBA) begin
      level = src.fba_cw[rpis_pkg::FBA_BIT];
    end else if (code == rpis_pkg::SEL_EFB) begin
      // Alternate profile uses an inverted stop-style bit
      if (!src.alt_profile) begin
        level = src.efb_cw[rpis_pkg::EFB_STD_BIT];
      end else if (INTERLOCK) begin
        level = ~src.efb_cw[rpis_pkg::EFB_ALT_INTLK_BIT];
      end else begin
        level = ~src.efb_cw[rpis_pkg::EFB_ALT_PERMIT_BIT];
      end
    end else if (code == rpis_pkg::SEL_OTHER) begin
      level = src.other_status[other_idx];
    end
  end

endmodule
`default_nettype wire

// >>> rtl/rpis_top.sv
// Run permit, start interlock and second-location command logic
//
// What this block does
// - Trigger code 1 makes start level-sensitive
// - Source one selector, default constant false
// - Source two selector, default constant false
// - Permit source 0 blocks motor running
// - Permit source 1 allows running; default code 1
// - Codes 0 and 1 give constants
// - Codes 2-7 route delayed inputs one-six
// - Codes 8-13 route inverted delayed inputs
// - Permit code 14 routes adapter bit 3
// - Permit code 15 routes embedded bit, profile-dependent
// - Any status bit selectable by index
// - Interlock source 0 inhibits starting
// - Interlock source 1 allows starting
// - Interlock selector resets to code 5
// - Pulse mode: edge starts, source two stops
// - Trigger type ignored in pulse mode
// - Interlock loss: none, coast or ramp
`timescale 1ns/1ps
`default_nettype none
module rpis_top (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [5:0] di_pin,
  input wire logic [15:0] fba_control_word,
  input wire logic [31:0] efb_control_word,
  input wire logic [31:0] other_status,
  output logic run_permit,
  output logic start_interlock_one,
  output logic motor_run,
  output logic coast_stop,
  output logic ramp_stop
);

  // ----------------------------------------------------------------
  // Types and helpers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_STOPPED,
    ST_RUNNING,
    ST_STOPPING
  } rpis_state_e;

  // Byte-lane merge for partial writes
  function automatic logic [31:0] rpis_merge(
    input logic [31:0] old,
    input logic [31:0] wdat,
    input logic [3:0] sel
  );
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = wdat[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Input synchroniser
  // ----------------------------------------------------------------
  logic [5:0] di_meta;
  logic [5:0] di_sync;
  logic [5:0] next_di_meta;
  logic [5:0] next_di_sync;

  always_comb begin
    next_di_meta = di_meta;
    next_di_sync = di_sync;
    if (ce) begin
      next_di_meta = di_pin;
      next_di_sync = di_meta;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      di_meta <= 6'h00;
      di_sync <= 6'h00;
    end else begin
      di_meta <= next_di_meta;
      di_sync <= next_di_sync;
    end
  end

  // ----------------------------------------------------------------
  // Register file and bus slave
  // ----------------------------------------------------------------
  logic [2:0] cmd_mode;
  logic trig_type;
  logic [4:0] src1_sel;
  logic [4:0] src2_sel;
  logic [4:0] permit_sel;
  logic [4:0] intlk_sel;
  logic [1:0] stop_mode;
  logic alt_profile;
  logic [4:0] other_idx [4];
  logic [2:0] next_cmd_mode;
  logic next_trig_type;
  logic [4:0] next_src1_sel;
  logic [4:0] next_src2_sel;
  logic [4:0] next_permit_sel;
  logic [4:0] next_intlk_sel;
  logic [1:0] next_stop_mode;
  logic next_alt_profile;
  logic [4:0] next_other_idx [4];
  logic [31:0] next_wb_dat_o;
  logic next_wb_ack_o;
  logic [31:0] rd_word;
  logic [31:0] wr_word;
  logic [31:0] status_word;
  logic bus_req;
  logic src1_lvl;
  logic src2_lvl;

  assign bus_req = wb_cyc_i & wb_stb_i;

  // Status shows registered outputs plus the combinational source one and two levels
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[0] = run_permit;
    status_word[1] = start_interlock_one;
    status_word[2] = motor_run;
    status_word[3] = coast_stop;
    status_word[4] = ramp_stop;
    status_word[5] = src1_lvl;
    status_word[6] = src2_lvl;
    status_word[13:8] = di_sync;
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    case (wb_adr_i)
      rpis_pkg::OFS_CMD_MODE: rd_word[2:0] = cmd_mode;
      rpis_pkg::OFS_TRIG_TYPE: rd_word[0] = trig_type;
      rpis_pkg::OFS_SRC1_SEL: rd_word[4:0] = src1_sel;
      rpis_pkg::OFS_SRC2_SEL: rd_word[4:0] = src2_sel;
      rpis_pkg::OFS_PERMIT_SEL: rd_word[4:0] = permit_sel;
      rpis_pkg::OFS_INTLK_SEL: rd_word[4:0] = intlk_sel;
      rpis_pkg::OFS_STOP_MODE: rd_word[1:0] = stop_mode;
      rpis_pkg::OFS_PROFILE: rd_word[0] = alt_profile;
      rpis_pkg::OFS_OTHER_IDX: begin
        for (int i = 0; i < 4; i++) begin
          rd_word[i*8 +: 5] = other_idx[i];
        end
      end
      rpis_pkg::OFS_STATUS: rd_word = status_word;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_comb begin
    next_cmd_mode = cmd_mode;
    next_trig_type = trig_type;
    next_src1_sel = src1_sel;
    next_src2_sel = src2_sel;
    next_permit_sel = permit_sel;
    next_intlk_sel = intlk_sel;
    next_stop_mode = stop_mode;
    next_alt_profile = alt_profile;
    next_other_idx = other_idx;
    next_wb_dat_o = wb_dat_o;
    next_wb_ack_o = wb_ack_o;
    wr_word = rpis_merge(rd_word, wb_dat_i, wb_sel_i);
    if (ce) begin
      // Ack lasts one cycle; write lands on the edge that ends the ack cycle
      next_wb_ack_o = bus_req & ~wb_ack_o;
      if (bus_req & ~wb_ack_o) begin
        next_wb_dat_o = wb_we_i ? 32'h0000_0000 : rd_word;
      end
      if (bus_req & wb_ack_o & wb_we_i) begin
        case (wb_adr_i)
          rpis_pkg::OFS_CMD_MODE: next_cmd_mode = wr_word[2:0];
          rpis_pkg::OFS_TRIG_TYPE: next_trig_type = wr_word[0];
          rpis_pkg::OFS_SRC1_SEL: next_src1_sel = wr_word[4:0];
          rpis_pkg::OFS_SRC2_SEL: next_src2_sel = wr_word[4:0];
          rpis_pkg::OFS_PERMIT_SEL: next_permit_sel = wr_word[4:0];
          rpis_pkg::OFS_INTLK_SEL: next_intlk_sel = wr_word[4:0];
          rpis_pkg::OFS_STOP_MODE: next_stop_mode = wr_word[1:0];
          rpis_pkg::OFS_PROFILE: next_alt_profile = wr_word[0];
          rpis_pkg::OFS_OTHER_IDX: begin
            for (int i = 0; i < 4; i++) begin
              next_other_idx[i] = wr_word[i*8 +: 5];
            end
          end
          default: next_cmd_mode = cmd_mode;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cmd_mode <= rpis_pkg::RST_CMD_MODE;
      trig_type <= rpis_pkg::RST_TRIG_TYPE;
      src1_sel <= rpis_pkg::RST_SRC_SEL;
      src2_sel <= rpis_pkg::RST_SRC_SEL;
      permit_sel <= rpis_pkg::RST_PERMIT_SEL;
      intlk_sel <= rpis_pkg::RST_INTLK_SEL;
      stop_mode <= rpis_pkg::RST_STOP_MODE;
      alt_profile <= rpis_pkg::RST_PROFILE;
      for (int i = 0; i < 4; i++) begin
        other_idx[i] <= rpis_pkg::RST_OTHER_IDX;
      end
      wb_dat_o <= 32'h0000_0000;
      wb_ack_o <= 1'b0;
    end else begin
      cmd_mode <= next_cmd_mode;
      trig_type <= next_trig_type;
      src1_sel <= next_src1_sel;
      src2_sel <= next_src2_sel;
      permit_sel <= next_permit_sel;
      intlk_sel <= next_intlk_sel;
      stop_mode <= next_stop_mode;
      alt_profile <= next_alt_profile;
      other_idx <= next_other_idx;
      wb_dat_o <= next_wb_dat_o;
      wb_ack_o <= next_wb_ack_o;
    end
  end

  // ----------------------------------------------------------------
  // Source selectors
  // ----------------------------------------------------------------
  rpis_src_if src_bus();
  logic permit_lvl;
  logic intlk_lvl;

  assign src_bus.di_delayed = di_sync;
  assign src_bus.fba_cw = fba_control_word;
  assign src_bus.efb_cw = efb_control_word;
  assign src_bus.alt_profile = alt_profile;
  assign src_bus.other_status = other_status;

  // Combinational selectors feed one register stage
  rpis_selector #(.INTERLOCK(1'b0)) u_sel_src1 (
    .code(src1_sel),
    .other_idx(other_idx[0]),
    .src(src_bus),
    .level(src1_lvl)
  );

  rpis_selector #(.INTERLOCK(1'b0)) u_sel_src2 (
    .code(src2_sel),
    .other_idx(other_idx[1]),
    .src(src_bus),
    .level(src2_lvl)
  );

  rpis_selector #(.INTERLOCK(1'b0)) u_sel_permit (
    .code(permit_sel),
    .other_idx(other_idx[2]),
    .src(src_bus),
    .level(permit_lvl)
  );

  rpis_selector #(.INTERLOCK(1'b1)) u_sel_intlk (
    .code(intlk_sel),
    .other_idx(other_idx[3]),
    .src(src_bus),
    .level(intlk_lvl)
  );

  // ----------------------------------------------------------------
  // Start and stop control
  // ----------------------------------------------------------------
  rpis_state_e state;
  rpis_state_e next_state;
  logic src1_prev;
  logic next_src1_prev;
  logic [1:0] stop_kind;
  logic [1:0] next_stop_kind;
  logic next_run_permit;
  logic next_start_interlock_one;
  logic next_motor_run;
  logic next_coast_stop;
  logic next_ramp_stop;
  logic start_req;
  logic keep_req;

  always_comb begin
    start_req = 1'b0;
    keep_req = 1'b0;
    case (cmd_mode)
      rpis_pkg::MODE_IN1_START: begin
        keep_req = src1_lvl;
        if (trig_type == rpis_pkg::TRIG_LEVEL) begin
          start_req = src1_lvl;
        end else begin
          start_req = src1_lvl & ~src1_prev;
        end
      end
      rpis_pkg::MODE_PULSE: begin
        // Trigger type plays no part here
        start_req = src1_lvl & ~src1_prev & src2_lvl;
        keep_req = src2_lvl;
      end
      default: begin
        start_req = 1'b0;
        keep_req = 1'b0;
      end
    endcase
  end

  always_comb begin
    next_state = state;
    next_stop_kind = stop_kind;
    next_src1_prev = src1_prev;
    next_run_permit = run_permit;
    next_start_interlock_one = start_interlock_one;
    next_motor_run = motor_run;
    next_coast_stop = coast_stop;
    next_ramp_stop = ramp_stop;
    if (ce) begin
      next_src1_prev = src1_lvl;
      unique case (state)
        ST_STOPPED: begin
          if (start_req & intlk_lvl) begin
            next_state = ST_RUNNING;
          end
        end
        ST_RUNNING: begin
          if (!keep_req) begin
            next_state = ST_STOPPED;
          end else if (!intlk_lvl && stop_mode != rpis_pkg::STOP_NONE) begin
            next_state = ST_STOPPING;
            next_stop_kind = stop_mode;
          end
        end
        ST_STOPPING: begin
          // Command must be withdrawn before a restart is possible
          if (!keep_req) begin
            next_state = ST_STOPPED;
          end
        end
      endcase
      next_run_permit = permit_lvl;
      next_start_interlock_one = intlk_lvl;
      next_motor_run = (next_state == ST_RUNNING) & permit_lvl;
      next_coast_stop = (next_state == ST_STOPPING) &
        (next_stop_kind == rpis_pkg::STOP_COAST);
      next_ramp_stop = (next_state == ST_STOPPING) &
        (next_stop_kind == rpis_pkg::STOP_RAMP);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= ST_STOPPED;
      stop_kind <= rpis_pkg::STOP_NONE;
      src1_prev <= 1'b0;
      run_permit <= 1'b0;
      start_interlock_one <= 1'b0;
      motor_run <= 1'b0;
      coast_stop <= 1'b0;
      ramp_stop <= 1'b0;
    end else begin
      state <= next_state;
      stop_kind <= next_stop_kind;
      src1_prev <= next_src1_prev;
      run_permit <= next_run_permit;
      start_interlock_one <= next_start_interlock_one;
      motor_run <= next_motor_run;
      coast_stop <= next_coast_stop;
      ramp_stop <= next_ramp_stop;
    end
  end

endmodule
`default_nettype wire

// >>> verification/rpis_checker.sv
// Port assertions for the run permit and interlock block
`timescale 1ns/1ps
`default_nettype none
module rpis_checker (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic run_permit,
  input wire logic start_interlock_one,
  input wire logic motor_run,
  input wire logic coast_stop,
  input wire logic ramp_stop
);
  logic stopping;
  assign stopping = coast_stop || ramp_stop;
  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // ------------------------------------------------------------
  // Sequences
  // ------------------------------------------------------------
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
  endsequence
  // Two cycles cover either source of the motor gate
  sequence permit_low_s;
    !run_permit ##1 !run_permit;
  endsequence
  ack_reply_a: assert property (req_s |=> wb_ack_o)
    else $error("ack missing after request");
  ack_pulse_a: assert property (wb_ack_o && ce |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  reset_clear_a: assert property ($fell(rst) |-> !(run_permit || motor_run || stopping))
    else $error("outputs not clear after reset");
  permit_default_a: assert property ($fell(rst) && ce |=> run_permit)
    else $error("permit not high after reset");
  permit_block_a: assert property (permit_low_s |-> !motor_run)
    else $error("motor runs without permit");
  stop_excl_a: assert property (!(coast_stop && ramp_stop))
    else $error("coast and ramp together");
  stop_norun_a: assert property (stopping |-> !motor_run)
    else $error("motor runs while stopping");
  stop_cause_a: assert property ($rose(stopping) |-> !start_interlock_one)
    else $error("stop without interlock loss");
  ce_hold_a: assert property (!ce |=> $stable(run_permit) && $stable(motor_run))
    else $error("outputs moved with ce low");
endmodule
bind rpis_top rpis_checker chk_u (.sys_clk, .rst, .ce, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .run_permit, .start_interlock_one, .motor_run, .coast_stop, .ramp_stop);
`default_nettype wire

// >>> verification/rpis_src_model.sv
// Model of the digital inputs and fieldbus control words
`timescale 1ns/1ps
`default_nettype none
module rpis_src_model (
  input wire logic sys_clk,
  output logic [5:0] di_pin,
  output logic [15:0] fba_control_word,
  output logic [31:0] efb_control_word,
  output logic [31:0] other_status
);
  // Sources change just after an edge, as same-clock logic would
  task automatic put(input logic [5:0] d, input logic [15:0] f,
    input logic [31:0] e, input logic [31:0] o);
    @(posedge sys_clk);
    di_pin <= d;
    fba_control_word <= f;
    efb_control_word <= e;
    other_status <= o;
  endtask
  initial begin
    di_pin = 6'h00;
    fba_control_word = 16'h0000;
    efb_control_word = 32'h0000_0000;
    other_status = 32'h0000_0000;
  end
endmodule
`default_nettype wire

// >>> verification/tb.sv
// Self-checking bench for the run permit and interlock block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_dat = 32'h0000_0000;
  logic [31:0] rdat;
  logic wb_ack, run_permit, intlk, motor_run, coast, ramp;
  logic [5:0] di_pin;
  logic [15:0] fba, cur_fba;
  logic [31:0] efb, oth, cur_efb, cur_oth;
  logic [5:0] cur_di;
  logic cur_alt = 1'b0;
  int n_fail = 0;
  int tests_run = 0;
  always #12.5 sys_clk = ~sys_clk;
  rpis_src_model src_u (.sys_clk, .di_pin, .fba_control_word(fba),
    .efb_control_word(efb), .other_status(oth));
  rpis_top dut_u (.sys_clk, .rst, .ce, .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat),
    .wb_dat_o(rdat), .wb_ack_o(wb_ack), .di_pin, .fba_control_word(fba),
    .efb_control_word(efb), .other_status(oth), .run_permit,
    .start_interlock_one(intlk), .motor_run, .coast_stop(coast), .ramp_stop(ramp));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic tally_and_finish();
    if (n_fail == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("unexpected %s exp %h got %h", n, e, g);
      n_fail++;
    end
  endtask
  task automatic chkb(input string n, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      $display("unexpected %s exp %b got %b", n, e, g);
      n_fail++;
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic src(input logic [5:0] d, input logic [15:0] f,
    input logic [31:0] e, input logic [31:0] o);
    cur_di = d;
    cur_fba = f;
    cur_efb = e;
    cur_oth = o;
    src_u.put(d, f, e, o);
  endtask
  // Slave latency is not assumed; the bound only catches a hang
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int i;
    @(posedge sys_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat <= d;
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (wb_ack !== 1'b1 && i < 20);
    q = rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (wb_ack !== 1'b1) begin
      n_fail++;
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0000_0000, q);
    chk(n, e, q);
  endtask
  function automatic logic exp_sel(input logic [4:0] c, input bit il);
    if (c < 5'h02) return c[0];
    if (c < 5'h08) return cur_di[c - 5'h02];
    if (c < 5'h0e) return ~cur_di[c - 5'h08];
    if (c == 5'h0e) return cur_fba[3];
    if (c == 5'h0f) return cur_alt ? ~cur_efb[il ? rpis_pkg::EFB_ALT_INTLK_BIT : 6] : cur_efb[3];
    if (c == 5'h10) return cur_oth[1];
    return 1'b0;
  endfunction
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    rd("src1_sel", rpis_pkg::OFS_SRC1_SEL, 32'h0000_0000);
    rd("src2_sel", rpis_pkg::OFS_SRC2_SEL, 32'h0000_0000);
    rd("permit_sel", rpis_pkg::OFS_PERMIT_SEL, 32'h0000_0001);
    rd("intlk_sel", rpis_pkg::OFS_INTLK_SEL, 32'h0000_0005);
    rd("unmapped", 8'h30, 32'h0000_0000);
    chkb("run_permit", 1'b1, run_permit);
    chkb("intlk", 1'b1, intlk);
    src(6'h00, 16'h0008, 32'h0000_0000, 32'h0000_0000);
    step(4);
    chkb("intlk", 1'b0, intlk);
  endtask
  task automatic t_table();
    logic [4:0] code;
    wr(rpis_pkg::OFS_OTHER_IDX, 32'h0101_0000);
    for (int p = 0; p < 2; p++) begin
      cur_alt = (p == 1);
      wr(rpis_pkg::OFS_PROFILE, {31'h0, cur_alt});
      if (p == 0) src(6'h15, 16'h0000, 32'h0000_0008, 32'h0000_0002);
      else src(6'h2a, 16'h0008, 32'h0000_0040, 32'h0000_0001);
      for (int c = 0; c < 21; c++) begin
        code = (c == 20) ? 5'h1f : 5'(c);
        wr(rpis_pkg::OFS_PERMIT_SEL, {27'h0, code});
        wr(rpis_pkg::OFS_INTLK_SEL, {27'h0, code});
        step(2);
        chkb("run_permit", exp_sel(code, 1'b0), run_permit);
        chkb("intlk", exp_sel(code, 1'b1), intlk);
      end
    end
  endtask
  task automatic t_timing();
    wr(rpis_pkg::OFS_PERMIT_SEL, 32'h0000_000e);
    src(6'h00, 16'h0008, 32'h0000_0000, 32'h0000_0000);
    step(3);
    chkb("run_permit", 1'b1, run_permit);
    src(6'h00, 16'h0000, 32'h0000_0000, 32'h0000_0000);
    step(1);
    chkb("run_permit", 1'b0, run_permit);
    @(posedge sys_clk);
    ce <= 1'b0;
    src(6'h00, 16'h0008, 32'h0000_0000, 32'h0000_0000);
    step(3);
    chkb("frozen permit", 1'b0, run_permit);
    @(posedge sys_clk);
    ce <= 1'b1;
    step(2);
    chkb("run_permit", 1'b1, run_permit);
  endtask
  task automatic t_level();
    wr(rpis_pkg::OFS_CMD_MODE, 32'h0000_0001);
    wr(rpis_pkg::OFS_SRC1_SEL, 32'h0000_0002);
    wr(rpis_pkg::OFS_INTLK_SEL, 32'h0000_0000);
    wr(rpis_pkg::OFS_STOP_MODE, 32'h0000_0001);
    wr(rpis_pkg::OFS_TRIG_TYPE, 32'h0000_0000);
    src(6'h01, 16'h0008, 32'h0000_0000, 32'h0000_0000);
    step(5);
    chkb("motor_run", 1'b0, motor_run);
    wr(rpis_pkg::OFS_INTLK_SEL, 32'h0000_0001);
    step(3);
    chkb("motor_run", 1'b0, motor_run);
    wr(rpis_pkg::OFS_TRIG_TYPE, 32'h0000_0001);
    step(3);
    chkb("motor_run", 1'b1, motor_run);
    wr(rpis_pkg::OFS_INTLK_SEL, 32'h0000_0000);
    step(3);
    chkb("coast_stop", 1'b1, coast);
    src(6'h00, 16'h0008, 32'h0000_0000, 32'h0000_0000);
    step(5);
    chkb("coast_stop", 1'b0, coast);
  endtask
  task automatic t_pulse();
    wr(rpis_pkg::OFS_INTLK_SEL, 32'h0000_0001);
    wr(rpis_pkg::OFS_STOP_MODE, 32'h0000_0000);
    wr(rpis_pkg::OFS_CMD_MODE, 32'h0000_0004);
    wr(rpis_pkg::OFS_SRC2_SEL, 32'h0000_0003);
    src(6'h01, 16'h0008, 32'h0000_0000, 32'h0000_0000);
    step(5);
    src(6'h03, 16'h0008, 32'h0000_0000, 32'h0000_0000);
    step(5);
    chkb("motor_run", 1'b0, motor_run);
    src(6'h02, 16'h0008, 32'h0000_0000, 32'h0000_0000);
    step(4);
    src(6'h03, 16'h0008, 32'h0000_0000, 32'h0000_0000);
    step(5);
    chkb("motor_run", 1'b1, motor_run);
    src(6'h02, 16'h0008, 32'h0000_0000, 32'h0000_0000);
    wr(rpis_pkg::OFS_INTLK_SEL, 32'h0000_0000);
    step(5);
    chkb("motor_run", 1'b1, motor_run);
    wr(rpis_pkg::OFS_PERMIT_SEL, 32'h0000_0000);
    step(3);
    chkb("motor_run", 1'b0, motor_run);
    wr(rpis_pkg::OFS_PERMIT_SEL, 32'h0000_0001);
    step(3);
    chkb("motor_run", 1'b1, motor_run);
    wr(rpis_pkg::OFS_INTLK_SEL, 32'h0000_0001);
    wr(rpis_pkg::OFS_STOP_MODE, 32'h0000_0002);
    wr(rpis_pkg::OFS_INTLK_SEL, 32'h0000_0000);
    step(3);
    chkb("ramp_stop", 1'b1, ramp);
    src(6'h00, 16'h0008, 32'h0000_0000, 32'h0000_0000);
    step(5);
    chkb("ramp_stop", 1'b0, ramp);
    chkb("motor_run", 1'b0, motor_run);
  endtask
  initial begin
    src(6'h08, 16'h0008, 32'h0000_0000, 32'h0000_0000);
    @(posedge sys_clk);
    rst <= 1'b0;
    step(4);
    t_reset();
    t_table();
    t_timing();
    t_level();
    t_pulse();
    tally_and_finish();
  end
endmodule
`default_nettype wire
